// ===== design/urwtc_pkg.sv
// Constants, types and the test packet table of the resume, wakeup and test mode control.
package urwtc_pkg;

    // ULPI transmit command bytes.
    localparam logic [7:0] TXCMD_REG_WRITE = 8'h84;
    localparam logic [7:0] TXCMD_NOPID     = 8'h40;
    localparam logic [7:0] TXCMD_NAK       = 8'h4a;
    localparam logic [7:0] TXCMD_DATA0     = 8'h43;

    // Function control register values written to the PHY.
    localparam logic [7:0] FC_FULL_SPEED   = 8'h45;
    localparam logic [7:0] FC_HIGH_SPEED   = 8'h40;
    localparam logic [7:0] FC_CHIRP        = 8'h54;

    // Data bytes streamed on the bus.
    localparam logic [7:0] CHIRP_J_BYTE    = 8'hff;
    localparam logic [7:0] CHIRP_K_BYTE    = 8'h00;
    localparam logic [7:0] IDLE_BYTE       = 8'h00;

    // Line state codes in the receive command.
    localparam logic [1:0] LS_SE0          = 2'h0;
    localparam logic [1:0] LS_FS_K         = 2'h2;

    // Test mode select register: field position, codes and value after reset.
    localparam int unsigned TM_LSB         = 0;
    localparam int unsigned TM_WIDTH       = 3;
    localparam logic [2:0] TM_NORMAL       = 3'h0;
    localparam logic [2:0] TM_CHIRP_J      = 3'h1;
    localparam logic [2:0] TM_CHIRP_K      = 3'h2;
    localparam logic [2:0] TM_NAK          = 3'h3;
    localparam logic [2:0] TM_PACKET       = 3'h4;
    localparam logic [31:0] TMS_RESET      = 32'h0000_0000;

    // Test packet length after the PID, as index of its last byte.
    localparam logic [5:0] TEST_PKT_LAST   = 6'h34;

    // Remote wakeup K duration, counted on the 60 MHz link clock.
    localparam int unsigned LINK_CLK_MHZ   = 60;
    localparam int unsigned WAKE_K_TIME_US = 3000;
    localparam int unsigned WAKE_K_CYCLES  = WAKE_K_TIME_US * LINK_CLK_MHZ;

    typedef enum logic [2:0] {
        ST_RUN      = 3'b000,
        ST_SUSP     = 3'b001,
        ST_WAKE_WR  = 3'b011,
        ST_WAKE_K   = 3'b010,
        ST_WAIT_SE0 = 3'b110,
        ST_RESTORE  = 3'b111,
        ST_TEST     = 3'b100
    } urwtc_link_state_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_CMD  = 2'b01,
        TX_DATA = 2'b11,
        TX_STOP = 2'b10
    } urwtc_tx_phase_t;

    // Byte of the standard test packet at the given index after the PID.
    function automatic logic [7:0] testPktByte(input logic [5:0] idx);
        logic [7:0] b;
        b = 8'hff;
        if (idx <= 6'h08) begin
            b = 8'h00;
        end else if (idx <= 6'h10) begin
            b = 8'haa;
        end else if (idx <= 6'h18) begin
            b = 8'hee;
        end else if (idx == 6'h19) begin
            b = 8'hfe;
        end else if (idx >= 6'h25 && idx <= 6'h2b) begin
            b[3'(6'h2c - idx)] = 1'b0;
        end else if (idx == 6'h2c) begin
            b = 8'hfc;
        end else if (idx == 6'h2d || idx == 6'h34) begin
            b = 8'h7e;
        end else if (idx >= 6'h2e && idx <= 6'h33) begin
            b[3'(6'h34 - idx)] = 1'b0;
        end
        return b;
    endfunction : testPktByte

endpackage : urwtc_pkg

// ===== design/urwtc_sync.sv
// Two flip-flop level synchroniser, one stage pair per bit.
`timescale 1ns/100ps

module urwtc_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Destination clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Levels in and out
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;

endmodule : urwtc_sync

// ===== design/urwtc_ctrl.sv
// Resume, remote wakeup and test mode control for the link side of a USB device engine.
// Overview of operation
// - Suspended: full-speed K sets resume status
// - After resume, wait for SE0 before leaving
// - Full-speed before suspend: write 0x45 at end
// - High-speed before suspend: write 0x40 at end
// - High-speed flag follows resumed speed
// - Suspended with wakeup enabled: write 0x54
// - Then NOPID 0x40, K for 3 ms, resume
// - Test mode zero means normal operation
// - Modes 001/010 send chirp J/K continuously
// - Mode 011 sends NAK, 100 test packet
// - Link logic runs on 60 MHz link clock
`timescale 1ns/100ps

module urwtc_ctrl #(
    parameter int unsigned WakeKCycles = urwtc_pkg::WAKE_K_CYCLES
) (
    // System clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Test mode select register access
    input  wire logic        tmsWrEn,
    input  wire logic [31:0] tmsWrData,
    output logic      [31:0] testModeSelect,
    // Control and status
    input  wire logic        remoteWakeupEnable,
    input  wire logic        resumeClear,
    output logic             resumeStatus,
    output logic             highSpeedEnabledFlag,
    output logic             suspendedFlag,
    // Link clock and engine signals on it
    input  wire logic        ulpiClk,
    input  wire logic        suspendEnter,
    input  wire logic        linkHighSpeed,
    // ULPI pins
    input  wire logic [7:0]  ulpiDataIn,
    input  wire logic        ulpiDir,
    input  wire logic        ulpiNxt,
    output logic      [7:0]  ulpiDataOut,
    output logic             ulpiDataOe,
    output logic             ulpiStp
);

    localparam int unsigned CW = $clog2(WakeKCycles + 1);

    ////////////////////////////////////////////////////////////////////////////////
    // System clock side.

    logic [31:0] tms_q;
    logic [2:0]  toRef;
    logic        resTglPrev_q;
    logic        resume_q;
    logic        hsFlag_q;
    logic        susp_q;
    logic        resumeEvt;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tms_q <= urwtc_pkg::TMS_RESET;
        end else if (tmsWrEn) begin
            tms_q <= tmsWrData;
        end
    end

    assign resumeEvt = toRef[0] ^ resTglPrev_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            resTglPrev_q <= 1'b0;
            resume_q     <= 1'b0;
            hsFlag_q     <= 1'b0;
            susp_q       <= 1'b0;
        end else begin
            resTglPrev_q <= toRef[0];
            // A resume event in the clearing cycle must not be lost.
            if (resumeEvt) begin
                resume_q <= 1'b1;
            end else if (resumeClear) begin
                resume_q <= 1'b0;
            end
            hsFlag_q <= toRef[1];
            susp_q   <= toRef[2];
        end
    end

    assign testModeSelect       = tms_q;
    assign resumeStatus         = resume_q;
    assign highSpeedEnabledFlag = hsFlag_q;
    assign suspendedFlag        = susp_q;

    a_resume_set_wins: assert property (@(posedge ref_clk) disable iff (rst)
        resumeEvt |=> resume_q)
        else $error("resume event did not set the resume status");

    ////////////////////////////////////////////////////////////////////////////////
    // Crossings. The test mode is taken only once two synchronised samples agree.

    logic                      resumeTgl_q;
    logic                      hsLink_q;
    logic                      suspLink_q;
    logic [3:0]                toLink;
    logic [2:0]                tmPrev_q;
    logic [2:0]                tmLink_q;
    logic                      wakeEnS;

    urwtc_sync #(.WIDTH(3)) u_to_ref (
        .clk  (ref_clk),
        .rst  (rst),
        .din  ({suspLink_q, hsLink_q, resumeTgl_q}),
        .dout (toRef)
    );

    urwtc_sync #(.WIDTH(4)) u_to_link (
        .clk  (ulpiClk),
        .rst  (rst),
        .din  ({remoteWakeupEnable, tms_q[urwtc_pkg::TM_LSB +: urwtc_pkg::TM_WIDTH]}),
        .dout (toLink)
    );

    assign wakeEnS = toLink[3];

    // Link logic is reset asynchronously; the reset pulse spans a link period.
    always_ff @(posedge ulpiClk or posedge rst) begin
        if (rst) begin
            tmPrev_q <= urwtc_pkg::TM_NORMAL;
            tmLink_q <= urwtc_pkg::TM_NORMAL;
        end else begin
            tmPrev_q <= toLink[2:0];
            if (tmPrev_q == toLink[2:0]) begin
                tmLink_q <= tmPrev_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Link clock side. ULPI pins are synchronous to this clock and are read directly.

    urwtc_pkg::urwtc_link_state_t state_q;
    urwtc_pkg::urwtc_tx_phase_t   txPhase_q;
    logic                         dirPrev_q;
    logic                         rxcmdValid;
    logic                         rxK;
    logic                         rxSe0;
    logic                         wakeUsed_q;
    logic                         hsBefore_q;
    logic [CW-1:0]                wakeCnt_q;
    logic                         wakeTimeUp;
    logic [5:0]                   txIdx_q;
    logic [5:0]                   nextIdx;
    logic [7:0]                   dataOut_q;
    logic                         oe_q;
    logic                         stp_q;
    logic                         txGo;
    logic                         txHasData;
    logic                         txLast;
    logic [7:0]                   txCmd;
    logic [7:0]                   txByte;
    logic                         txDone;

    assign rxcmdValid = ulpiDir && dirPrev_q && !ulpiNxt;
    assign rxK        = rxcmdValid && (ulpiDataIn[1:0] == urwtc_pkg::LS_FS_K);
    assign rxSe0      = rxcmdValid && (ulpiDataIn[1:0] == urwtc_pkg::LS_SE0);
    assign txDone     = (txPhase_q == urwtc_pkg::TX_STOP);
    assign wakeTimeUp = (wakeCnt_q == CW'(WakeKCycles - 1));
    assign nextIdx    = (txPhase_q == urwtc_pkg::TX_DATA) ? txIdx_q + 6'h01 : 6'h00;

    // Link state machine, clocked by the PHY's 60 MHz clock.
    always_ff @(posedge ulpiClk or posedge rst) begin
        if (rst) begin
            state_q <= urwtc_pkg::ST_RUN;
        end else begin
            case (state_q)
                urwtc_pkg::ST_RUN: begin
                    if (suspendEnter) begin
                        state_q <= urwtc_pkg::ST_SUSP;
                    end else if (tmLink_q != urwtc_pkg::TM_NORMAL) begin
                        state_q <= urwtc_pkg::ST_TEST;
                    end
                end
                urwtc_pkg::ST_SUSP: begin
                    if (rxK) begin
                        state_q <= urwtc_pkg::ST_WAIT_SE0;
                    end else if (wakeEnS && !wakeUsed_q) begin
                        state_q <= urwtc_pkg::ST_WAKE_WR;
                    end
                end
                urwtc_pkg::ST_WAKE_WR: begin
                    if (txDone) begin
                        state_q <= urwtc_pkg::ST_WAKE_K;
                    end
                end
                urwtc_pkg::ST_WAKE_K: begin
                    if (txDone) begin
                        state_q <= urwtc_pkg::ST_WAIT_SE0;
                    end
                end
                urwtc_pkg::ST_WAIT_SE0: begin
                    // The host keeps K going until it ends resume with SE0.
                    if (rxSe0) begin
                        state_q <= urwtc_pkg::ST_RESTORE;
                    end
                end
                urwtc_pkg::ST_RESTORE: begin
                    if (txDone) begin
                        state_q <= urwtc_pkg::ST_RUN;
                    end
                end
                urwtc_pkg::ST_TEST: begin
                    if (tmLink_q == urwtc_pkg::TM_NORMAL && txPhase_q == urwtc_pkg::TX_IDLE) begin
                        state_q <= urwtc_pkg::ST_RUN;
                    end
                end
                default: begin
                    state_q <= urwtc_pkg::ST_RUN;
                end
            endcase
        end
    end

    // Suspend bookkeeping, resume event toggle and high-speed flag.
    always_ff @(posedge ulpiClk or posedge rst) begin
        if (rst) begin
            dirPrev_q   <= 1'b0;
            wakeUsed_q  <= 1'b0;
            hsBefore_q  <= 1'b0;
            hsLink_q    <= 1'b0;
            resumeTgl_q <= 1'b0;
            suspLink_q  <= 1'b0;
        end else begin
            dirPrev_q  <= ulpiDir;
            suspLink_q <= state_q inside {urwtc_pkg::ST_SUSP, urwtc_pkg::ST_WAKE_WR,
                                          urwtc_pkg::ST_WAKE_K, urwtc_pkg::ST_WAIT_SE0};
            if (state_q == urwtc_pkg::ST_RUN && suspendEnter) begin
                wakeUsed_q <= 1'b0;
                hsBefore_q <= linkHighSpeed;
            end else if (state_q == urwtc_pkg::ST_SUSP && !rxK && wakeEnS) begin
                wakeUsed_q <= 1'b1;
            end
            if ((state_q == urwtc_pkg::ST_SUSP && rxK) ||
                (state_q == urwtc_pkg::ST_WAKE_WR && txDone)) begin
                resumeTgl_q <= !resumeTgl_q;
            end
            if (state_q == urwtc_pkg::ST_RESTORE && txDone) begin
                hsLink_q <= hsBefore_q;
            end else if (state_q == urwtc_pkg::ST_RUN) begin
                hsLink_q <= linkHighSpeed;
            end
        end
    end

    // Length of the wakeup K, long enough that the host sees it well past 1 ms.
    always_ff @(posedge ulpiClk or posedge rst) begin
        if (rst) begin
            wakeCnt_q <= '0;
        end else if (state_q != urwtc_pkg::ST_WAKE_K) begin
            wakeCnt_q <= '0;
        end else if (!wakeTimeUp) begin
            wakeCnt_q <= wakeCnt_q + CW'(1);
        end
    end

    // What the current state wants to transmit.
    always_comb begin
        txGo      = 1'b0;
        txCmd     = urwtc_pkg::TXCMD_NOPID;
        txHasData = 1'b1;
        txLast    = 1'b0;
        txByte    = urwtc_pkg::CHIRP_K_BYTE;
        case (state_q)
            urwtc_pkg::ST_WAKE_WR: begin
                txGo   = 1'b1;
                txCmd  = urwtc_pkg::TXCMD_REG_WRITE;
                txByte = urwtc_pkg::FC_CHIRP;
                txLast = 1'b1;
            end
            urwtc_pkg::ST_RESTORE: begin
                txGo   = 1'b1;
                txCmd  = urwtc_pkg::TXCMD_REG_WRITE;
                txByte = hsBefore_q ? urwtc_pkg::FC_HIGH_SPEED : urwtc_pkg::FC_FULL_SPEED;
                txLast = 1'b1;
            end
            urwtc_pkg::ST_WAKE_K: begin
                txGo   = 1'b1;
                txLast = wakeTimeUp;
            end
            urwtc_pkg::ST_TEST: begin
                txGo = 1'b1;
                case (tmLink_q)
                    urwtc_pkg::TM_CHIRP_J: begin
                        txByte = urwtc_pkg::CHIRP_J_BYTE;
                    end
                    urwtc_pkg::TM_CHIRP_K: begin
                        txByte = urwtc_pkg::CHIRP_K_BYTE;
                    end
                    urwtc_pkg::TM_NAK: begin
                        txCmd     = urwtc_pkg::TXCMD_NAK;
                        txHasData = 1'b0;
                    end
                    urwtc_pkg::TM_PACKET: begin
                        txCmd  = urwtc_pkg::TXCMD_DATA0;
                        txByte = urwtc_pkg::testPktByte(nextIdx);
                        txLast = (txIdx_q == urwtc_pkg::TEST_PKT_LAST);
                    end
                    default: begin
                        txGo   = 1'b0;
                        txLast = 1'b1;
                    end
                endcase
            end
            default: begin
                txGo = 1'b0;
            end
        endcase
    end

    // ULPI transmit sequencer. A turnaround by the PHY aborts and the state retries.
    always_ff @(posedge ulpiClk or posedge rst) begin
        if (rst) begin
            txPhase_q <= urwtc_pkg::TX_IDLE;
            txIdx_q   <= '0;
            dataOut_q <= urwtc_pkg::IDLE_BYTE;
            oe_q      <= 1'b0;
            stp_q     <= 1'b0;
        end else if (ulpiDir && txPhase_q != urwtc_pkg::TX_IDLE) begin
            txPhase_q <= urwtc_pkg::TX_IDLE;
            dataOut_q <= urwtc_pkg::IDLE_BYTE;
            oe_q      <= 1'b0;
            stp_q     <= 1'b0;
        end else begin
            case (txPhase_q)
                urwtc_pkg::TX_IDLE: begin
                    stp_q <= 1'b0;
                    if (txGo && !ulpiDir) begin
                        dataOut_q <= txCmd;
                        oe_q      <= 1'b1;
                        txIdx_q   <= '0;
                        txPhase_q <= urwtc_pkg::TX_CMD;
                    end else begin
                        dataOut_q <= urwtc_pkg::IDLE_BYTE;
                        oe_q      <= 1'b0;
                    end
                end
                urwtc_pkg::TX_CMD: begin
                    if (ulpiNxt && txHasData) begin
                        dataOut_q <= txByte;
                        txIdx_q   <= '0;
                        txPhase_q <= urwtc_pkg::TX_DATA;
                    end else if (ulpiNxt) begin
                        dataOut_q <= urwtc_pkg::IDLE_BYTE;
                        stp_q     <= 1'b1;
                        txPhase_q <= urwtc_pkg::TX_STOP;
                    end
                end
                urwtc_pkg::TX_DATA: begin
                    if (ulpiNxt && txLast) begin
                        dataOut_q <= urwtc_pkg::IDLE_BYTE;
                        stp_q     <= 1'b1;
                        txPhase_q <= urwtc_pkg::TX_STOP;
                    end else if (ulpiNxt) begin
                        dataOut_q <= txByte;
                        txIdx_q   <= nextIdx;
                    end
                end
                default: begin
                    stp_q     <= 1'b0;
                    oe_q      <= 1'b0;
                    txPhase_q <= urwtc_pkg::TX_IDLE;
                end
            endcase
        end
    end

    assign ulpiDataOut = dataOut_q;
    assign ulpiDataOe  = oe_q;
    assign ulpiStp     = stp_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on the link side.

    sequence s_host_k;
        state_q == urwtc_pkg::ST_SUSP && rxK;
    endsequence

    sequence s_restore_data;
        state_q == urwtc_pkg::ST_RESTORE && txPhase_q == urwtc_pkg::TX_DATA;
    endsequence

    a_host_k_resume: assert property (@(posedge ulpiClk) disable iff (rst)
        s_host_k |=> state_q == urwtc_pkg::ST_WAIT_SE0 && resumeTgl_q != $past(resumeTgl_q))
        else $error("full-speed K in suspend did not start resume");

    a_wait_end_se0: assert property (@(posedge ulpiClk) disable iff (rst)
        (state_q == urwtc_pkg::ST_WAIT_SE0 && !rxSe0) |=> state_q == urwtc_pkg::ST_WAIT_SE0)
        else $error("resume ended without SE0");

    a_fs_restore_value: assert property (@(posedge ulpiClk) disable iff (rst)
        (s_restore_data and !hsBefore_q) |-> dataOut_q == urwtc_pkg::FC_FULL_SPEED)
        else $error("full-speed restore wrote a wrong value");

    a_hs_restore_value: assert property (@(posedge ulpiClk) disable iff (rst)
        (s_restore_data and hsBefore_q) |-> dataOut_q == urwtc_pkg::FC_HIGH_SPEED)
        else $error("high-speed restore wrote a wrong value");

    a_hs_flag_update: assert property (@(posedge ulpiClk) disable iff (rst)
        (state_q == urwtc_pkg::ST_RESTORE && txDone) |=>
            state_q == urwtc_pkg::ST_RUN && hsLink_q == $past(hsBefore_q))
        else $error("high-speed flag not updated after resume");

    a_wake_chirp_write: assert property (@(posedge ulpiClk) disable iff (rst)
        (state_q == urwtc_pkg::ST_WAKE_WR && txPhase_q == urwtc_pkg::TX_DATA) |->
            dataOut_q == urwtc_pkg::FC_CHIRP && txIdx_q == 6'h00)
        else $error("wakeup did not write the chirp value");

    a_wake_nopid_k: assert property (@(posedge ulpiClk) disable iff (rst)
        (state_q == urwtc_pkg::ST_WAKE_WR && txDone) |=>
            state_q == urwtc_pkg::ST_WAKE_K && txPhase_q == urwtc_pkg::TX_IDLE ##1
            ($past(ulpiDir) || (dataOut_q == urwtc_pkg::TXCMD_NOPID && oe_q)))
        else $error("wakeup K not started with NOPID");

    a_normal_when_zero: assert property (@(posedge ulpiClk) disable iff (rst)
        (state_q == urwtc_pkg::ST_RUN && tmLink_q == urwtc_pkg::TM_NORMAL) |=>
            state_q != urwtc_pkg::ST_TEST)
        else $error("test mode entered with a zero field");

    a_test_chirp_byte: assert property (@(posedge ulpiClk) disable iff (rst)
        (state_q == urwtc_pkg::ST_TEST && txPhase_q == urwtc_pkg::TX_DATA && ulpiNxt &&
         !ulpiDir && tmLink_q == urwtc_pkg::TM_CHIRP_J) |=>
            dataOut_q == urwtc_pkg::CHIRP_J_BYTE && oe_q)
        else $error("chirp J test mode sent a wrong byte");

    a_test_nak_cmd: assert property (@(posedge ulpiClk) disable iff (rst)
        (state_q == urwtc_pkg::ST_TEST && tmLink_q == urwtc_pkg::TM_NAK &&
         txPhase_q == urwtc_pkg::TX_CMD) |-> dataOut_q == urwtc_pkg::TXCMD_NAK)
        else $error("NAK test mode sent a wrong command");

    a_wake_once_only: assert property (@(posedge ulpiClk) disable iff (rst)
        (state_q == urwtc_pkg::ST_SUSP && wakeUsed_q) |=> state_q != urwtc_pkg::ST_WAKE_WR)
        else $error("wakeup started twice in one suspend");

    a_wake_only_susp: assert property (@(posedge ulpiClk) disable iff (rst)
        (state_q != urwtc_pkg::ST_SUSP && state_q != urwtc_pkg::ST_WAKE_WR) |=>
            state_q != urwtc_pkg::ST_WAKE_WR)
        else $error("wakeup started outside suspend");

endmodule : urwtc_ctrl

// ===== tb/urwtc_phy_model.sv
// Behavioural ULPI PHY: accepts link bytes and reports line states.
`timescale 1ns/100ps
module urwtc_phy_model (
    // Link side
    input  wire logic       ulpiClk,
    input  wire logic       ulpiDataOe,
    input  wire logic       slow,
    // PHY pins
    output logic            ulpiDir,
    output logic            ulpiNxt,
    output logic [7:0]      ulpiDataIn
);
    initial begin
        ulpiDir = 1'b0;
        ulpiNxt = 1'b0;
        ulpiDataIn = 8'h5a;
    end
    // A released data bus keeps changing, so a stale byte is never read as valid.
    always @(posedge ulpiClk) begin
        #1 ulpiNxt <= ulpiDataOe & !ulpiDir & (!slow | !ulpiNxt);
        if (!ulpiDir) ulpiDataIn <= ~ulpiDataIn;
    end
    // Turnaround, then one receive command carrying the host's line state.
    task automatic lineState(input logic [1:0] ls);
        @(posedge ulpiClk);
        while (ulpiDataOe) @(posedge ulpiClk);
        #1 ulpiDir = 1'b1;
        @(posedge ulpiClk);
        #1 ulpiDataIn = {6'h00, ls};
        @(posedge ulpiClk);
        #1 ulpiDir = 1'b0;
    endtask : lineState
endmodule : urwtc_phy_model

// ===== tb/urwtc_ctrl_tb_top.sv
// Self-checking bench of the resume, wakeup and test mode control.
`timescale 1ns/100ps
module urwtc_ctrl_tb_top;
    logic        ref_clk, rst, tmsWrEn, remoteWakeupEnable, resumeClear, resumeStatus;
    logic        highSpeedEnabledFlag, suspendedFlag, ulpiClk, suspendEnter, linkHighSpeed;
    logic        ulpiDir, ulpiNxt, ulpiDataOe, ulpiStp, slow, strict;
    logic [31:0] tmsWrData, testModeSelect, d;
    logic [7:0]  ulpiDataIn, ulpiDataOut, first;
    logic [15:0] exp[$];
    logic [15:0] tm[1:4] = '{16'h40ff, 16'h4000, 16'h4a00, 16'h4300};
    int          numErrors = 0, nTests = 0, cnt = 0;

    urwtc_ctrl #(.WakeKCycles(20)) dut (.ref_clk(ref_clk), .rst(rst), .tmsWrEn(tmsWrEn),
        .tmsWrData(tmsWrData), .testModeSelect(testModeSelect), .resumeClear(resumeClear),
        .remoteWakeupEnable(remoteWakeupEnable), .resumeStatus(resumeStatus),
        .highSpeedEnabledFlag(highSpeedEnabledFlag), .suspendedFlag(suspendedFlag),
        .ulpiClk(ulpiClk), .suspendEnter(suspendEnter), .linkHighSpeed(linkHighSpeed),
        .ulpiDataIn(ulpiDataIn), .ulpiDir(ulpiDir), .ulpiNxt(ulpiNxt),
        .ulpiDataOut(ulpiDataOut), .ulpiDataOe(ulpiDataOe), .ulpiStp(ulpiStp));
    urwtc_phy_model phy (.ulpiClk(ulpiClk), .ulpiDataOe(ulpiDataOe), .slow(slow),
        .ulpiDir(ulpiDir), .ulpiNxt(ulpiNxt), .ulpiDataIn(ulpiDataIn));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        ulpiClk = 1'b0;
        #1.7;
        forever #3 ulpiClk = ~ulpiClk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] want);
        nTests++;
        if (got !== want) begin
            numErrors++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask : check
    // A transfer is judged by its first two accepted bytes; a lone byte pairs with zero.
    always @(posedge ulpiClk) begin
        if (!ulpiDataOe || ulpiDir || ulpiStp) begin
            if (ulpiStp && cnt == 1 && exp.size() > 0)
                check({first, 8'h00}, exp.pop_front());
            else if (ulpiStp && cnt == 1 && strict) check({first, 8'h00}, 32'h0);
            cnt = 0;
        end else if (ulpiNxt) begin
            if (cnt == 0) first = ulpiDataOut;
            else if (cnt == 1 && exp.size() > 0)
                check({first, ulpiDataOut}, exp.pop_front());
            else if (cnt == 1 && strict) check({first, ulpiDataOut}, 32'h0);
            cnt++;
        end
    end
    task automatic refOp(input logic we, input logic [31:0] v, input logic clr);
        @(posedge ref_clk);
        #1 tmsWrEn = we;
        tmsWrData = v;
        resumeClear = clr;
        @(posedge ref_clk);
        #1 tmsWrEn = 1'b0;
        resumeClear = 1'b0;
    endtask : refOp
    task automatic susp(input logic hs);
        @(posedge ulpiClk);
        #1 linkHighSpeed = hs;
        suspendEnter = 1'b1;
        @(posedge ulpiClk);
        #1 suspendEnter = 1'b0;
    endtask : susp
    task automatic drain(input int id);
        for (int i = 0; i < 2000 && exp.size() > 0; i++) @(posedge ulpiClk);
        repeat (10) @(posedge ref_clk);
        #1 check(exp.size(), 0);
        $display("test %0d done", id);
    endtask : drain
    task automatic completeRun();
        $display("comparisons %0d, mismatches %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : completeRun

    initial begin
        {rst, tmsWrEn, tmsWrData, remoteWakeupEnable, resumeClear} = {1'b1, 35'h0};
        {suspendEnter, linkHighSpeed, slow, strict} = 4'h1;
        void'($urandom(32'h746f));
        repeat (16) @(posedge ref_clk);
        #1 rst = 1'b0;
        check(testModeSelect, 32'h0);
        d = $urandom & 32'hffff_fff8;
        refOp(1'b1, d, 1'b0);
        check(testModeSelect, d);
        slow = 1'($urandom);
        exp.push_back({urwtc_pkg::TXCMD_REG_WRITE, urwtc_pkg::FC_HIGH_SPEED});
        susp(1'b1);
        phy.lineState(urwtc_pkg::LS_FS_K);
        repeat (10) @(posedge ref_clk);
        #1 check(resumeStatus, 1'b1);
        check(suspendedFlag, 1'b1);
        check(exp.size(), 1);
        phy.lineState(urwtc_pkg::LS_SE0);
        drain(1);
        check(highSpeedEnabledFlag, 1'b1);
        check(suspendedFlag, 1'b0);
        refOp(1'b0, d, 1'b1);
        check(resumeStatus, 1'b0);
        remoteWakeupEnable = 1'b1;
        repeat (40) @(posedge ulpiClk);
        slow = 1'($urandom);
        exp.push_back({urwtc_pkg::TXCMD_REG_WRITE, urwtc_pkg::FC_CHIRP});
        exp.push_back({urwtc_pkg::TXCMD_NOPID, 8'h00});
        exp.push_back({urwtc_pkg::TXCMD_REG_WRITE, urwtc_pkg::FC_FULL_SPEED});
        susp(1'b0);
        repeat (150) @(posedge ulpiClk);
        #1 check(exp.size(), 1);
        check(resumeStatus, 1'b1);
        phy.lineState(urwtc_pkg::LS_SE0);
        drain(2);
        check(highSpeedEnabledFlag, 1'b0);
        remoteWakeupEnable = 1'b0;
        strict = 1'b0;
        for (int m = 1; m < 5; m++) begin
            exp.push_back(tm[m]);
            refOp(1'b1, {d[31:3], 3'(m)}, 1'b0);
            drain(m + 2);
            refOp(1'b1, d, 1'b0);
            repeat (300) @(posedge ulpiClk);
        end
        strict = 1'b1;
        repeat (100) @(posedge ulpiClk);
        completeRun();
    end
    initial begin
        #500_000;
        check(32'h0, 32'h1);
        completeRun();
    end
endmodule : urwtc_ctrl_tb_top
